// >>> verilog/iwd_pkg.sv
/*
  Package of the I/O port watchdog: port address, interval codes, timing counts,
  power-on arming encodings, state machine codes and the host access carrier.
  Assumes one 100 MHz system clock.
*/
package iwd_pkg;

  localparam logic [15:0] IWD_PORT_ADDR      = 16'h0443;
  localparam logic [7:0]  IWD_CODE_MIN       = 8'h01;
  localparam logic [7:0]  IWD_CODE_MAX       = 8'h3F;
  localparam int          IWD_CODE_W         = 6;
  localparam int          IWD_CLK_HZ         = 100_000_000;
  localparam int          IWD_TICK_S         = 1;
  localparam int          IWD_TICK_CYC       = IWD_CLK_HZ * IWD_TICK_S;
  localparam int          IWD_TICK_W         = 27;
  localparam int          IWD_RST_PULSE_CYC  = 16;
  localparam logic [7:0]  IWD_RST_PULSE_LAST = 8'(IWD_RST_PULSE_CYC - 1);

  // Power-on arming selection from setup configuration.
  localparam logic [1:0]  IWD_PON_63S        = 2'h0;
  localparam logic [1:0]  IWD_PON_OFF        = 2'h1;
  localparam logic [1:0]  IWD_PON_31S        = 2'h2;
  localparam logic [1:0]  IWD_PON_15S        = 2'h3;
  localparam logic [5:0]  IWD_IVL_63         = 6'h3F;
  localparam logic [5:0]  IWD_IVL_31         = 6'h1F;
  localparam logic [5:0]  IWD_IVL_15         = 6'h0F;
  localparam logic [7:0]  IWD_READ_DATA      = 8'h00;

  typedef enum logic [3:0] {
    IWD_ST_BOOT = 4'h1,
    IWD_ST_IDLE = 4'h2,
    IWD_ST_RUN  = 4'h4,
    IWD_ST_FIRE = 4'h8
  } iwd_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } iwd_io_s;

endpackage

// >>> verilog/iwd_tick.sv
/*
  One-second tick divider. Emits a one-cycle enable every IWD_TICK_CYC cycles
  while run is high; restarts its phase on clr. Assumes the 100 MHz clock.
*/
module iwd_tick #(
  parameter int TICK_CYC = iwd_pkg::IWD_TICK_CYC
) (
  input  wire logic clk_sys, // System clock.
  input  wire logic rstn,    // Asynchronous reset, active low.
  input  wire logic run,     // Count while high.
  input  wire logic clr,     // Restart the second.
  output logic      tick     // One-cycle pulse per second.
);

  localparam logic [iwd_pkg::IWD_TICK_W-1:0] LAST = iwd_pkg::IWD_TICK_W'(TICK_CYC - 1);

  logic [iwd_pkg::IWD_TICK_W-1:0] cnt_q;
  logic [iwd_pkg::IWD_TICK_W-1:0] cnt_d;
  wire                            at_end = (cnt_q == LAST);

  assign cnt_d = (clr || !run || at_end) ? '0 : cnt_q + 1'b1;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= run && !clr && at_end;
    end
  end

endmodule

// >>> verilog/iwd_top.sv
/*
  I/O port watchdog timer. The host writes an interval code to one byte port to
  start or refresh the countdown and reads the port to disarm it. Expiry gives a
  processor reset pulse or an interrupt request level.
  Assumes host strobes are one-cycle pulses synchronous to clk_sys.
*/
//////////////////////////////////////////////////////////////////////////////
module iwd_top #(
  parameter int TICK_CYC = iwd_pkg::IWD_TICK_CYC
) (
  input  wire logic             clk_sys,   // System clock, 100 MHz.
  input  wire logic             rstn,      // Asynchronous reset, active low.
  input  wire iwd_pkg::iwd_io_s io,        // Host port access, strobes one cycle.
  input  wire logic [1:0]       pon_sel,   // Power-on arming selection.
  input  wire logic             irq_mode,  // 1: interrupt on expiry, 0: reset.
  output logic [7:0]            rdata,     // Read data for the port.
  output logic                  rdata_vld, // Read data valid pulse.
  output logic                  cpu_rst,   // Processor reset pulse, active high.
  output logic                  irq,       // Interrupt request level.
  output logic                  running,   // Countdown active.
  output logic [5:0]            remain     // Seconds left.
);

  iwd_pkg::iwd_state_e state_q;
  iwd_pkg::iwd_state_e state_d;
  logic [5:0]          cnt_q;
  logic [5:0]          cnt_d;
  logic [7:0]          fire_q;
  logic [7:0]          fire_d;
  logic                irq_q;
  logic                irq_d;
  logic                tick;

  //////////////////////////////////////////////////////////////////////////////
  // Port decode.

  wire hit      = (io.addr == iwd_pkg::IWD_PORT_ADDR);
  wire code_ok  = (io.wdata >= iwd_pkg::IWD_CODE_MIN) &&
                  (io.wdata <= iwd_pkg::IWD_CODE_MAX);
  // Out-of-range codes, zero among them, leave the timer exactly as it was.
  // Should a write with an in-range code and a read meet in one cycle, the write is taken.
  wire wr_load  = hit && io.wr && code_ok;
  wire rd_stop  = hit && io.rd && !wr_load;
  wire [5:0] wr_ivl = io.wdata[iwd_pkg::IWD_CODE_W-1:0];

  wire pon_arm  = (pon_sel != iwd_pkg::IWD_PON_OFF);
  wire [5:0] pon_ivl = (pon_sel == iwd_pkg::IWD_PON_31S) ? iwd_pkg::IWD_IVL_31 :
                       (pon_sel == iwd_pkg::IWD_PON_15S) ? iwd_pkg::IWD_IVL_15 :
                       iwd_pkg::IWD_IVL_63;

  // A read or an in-range write in the last cycle of the last second wins over expiry, so a
  // refresh that arrives just in time is never followed by a reset.
  wire in_run     = (state_q == iwd_pkg::IWD_ST_RUN);
  wire last_sec   = (cnt_q == 6'h01);
  wire expire     = in_run && tick && last_sec && !wr_load && !rd_stop;
  wire pulse_done = !irq_q && (fire_q == iwd_pkg::IWD_RST_PULSE_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // One-second tick, restarted on every reload so each second is whole.

  iwd_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (in_run),
    .clr     (wr_load),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    fire_d  = fire_q;
    irq_d   = irq_q;
    case (state_q)
      iwd_pkg::IWD_ST_BOOT: begin
        // One cycle after reset the setup choice arms the timer; host accesses
        // in this cycle are not taken.
        cnt_d   = pon_arm ? pon_ivl : 6'h00;
        state_d = pon_arm ? iwd_pkg::IWD_ST_RUN : iwd_pkg::IWD_ST_IDLE;
      end
      iwd_pkg::IWD_ST_IDLE: begin
        if (wr_load) begin
          cnt_d   = wr_ivl;
          state_d = iwd_pkg::IWD_ST_RUN;
        end
      end
      iwd_pkg::IWD_ST_RUN: begin
        if (wr_load) begin
          cnt_d = wr_ivl;
        end else if (rd_stop) begin
          state_d = iwd_pkg::IWD_ST_IDLE;
        end else if (expire) begin
          cnt_d   = 6'h00;
          fire_d  = 8'h00;
          state_d = iwd_pkg::IWD_ST_FIRE;
          if (irq_mode) begin
            irq_d = 1'b1;
          end
        end else if (tick) begin
          cnt_d = cnt_q - 6'h01;
        end
      end
      iwd_pkg::IWD_ST_FIRE: begin
        // In interrupt mode the request stays up until the host writes an in-range code or reads.
        fire_d = fire_q + 8'h01;
        if (wr_load) begin
          cnt_d   = wr_ivl;
          irq_d   = 1'b0;
          state_d = iwd_pkg::IWD_ST_RUN;
        end else if (rd_stop) begin
          irq_d   = 1'b0;
          state_d = iwd_pkg::IWD_ST_IDLE;
        end else if (pulse_done) begin
          state_d = iwd_pkg::IWD_ST_IDLE;
        end
      end
      default: begin
        state_d = iwd_pkg::IWD_ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output next values. cpu_rst and running are plain copies of rst_on and run_on, so
  // these pins move only on the clock edge that also moves the state.

  wire rst_on  = (state_d == iwd_pkg::IWD_ST_FIRE) && !irq_d;
  wire run_on  = (state_d == iwd_pkg::IWD_ST_RUN);
  wire rd_seen = hit && io.rd;

  //////////////////////////////////////////////////////////////////////////////
  // State and counters.

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= iwd_pkg::IWD_ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fire_q <= 8'h00;
    end else begin
      fire_q <= fire_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers.

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_rst <= 1'b0;
    end else begin
      cpu_rst <= rst_on;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      running <= 1'b0;
    end else begin
      running <= run_on;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      remain <= 6'h00;
    end else begin
      remain <= cnt_d;
    end
  end

  // The port reads back a fixed byte; the read access itself is what disarms.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= iwd_pkg::IWD_READ_DATA;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_vld <= 1'b0;
    end else begin
      rdata_vld <= rd_seen;
    end
  end

endmodule

// >>> testbench/iwd_monitor.sv
/* Port checker of the watchdog.
   Assumes one clock domain with reset rstn. */
module iwd_monitor (
  input wire logic             clk_sys,   // Clock.
  input wire logic             rstn,      // Reset.
  input wire iwd_pkg::iwd_io_s io,        // Host access.
  input wire logic             irq_mode,  // Expiry mode.
  input wire logic             rdata_vld, // Read answer.
  input wire logic             cpu_rst,   // Reset pulse.
  input wire logic             irq,       // Interrupt.
  input wire logic             running,   // Counting.
  input wire logic [5:0]       remain     // Seconds left.
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  wire logic hit = io.addr == iwd_pkg::IWD_PORT_ADDR;
  wire logic req = hit && (io.wr || io.rd);
  wire logic rd_hit = hit && io.rd && !io.wr;
  wire logic rd_req = hit && io.rd;
  wire logic load = hit && io.wr && io.wdata != 8'h00 && io.wdata <= iwd_pkg::IWD_CODE_MAX;
  sequence s_last;
    running && remain == 6'h01 && !req;
  endsequence
  sequence s_pulse;
    cpu_rst [*8] ##1 cpu_rst [*8];
  endsequence
  AST_LOAD: assert property (load |=> running && remain == $past(io.wdata[5:0]))
    else $error("load not taken");
  AST_DISARM: assert property (rd_hit |=> !running && rdata_vld)
    else $error("read did not disarm");
  AST_RDVLD: assert property (rdata_vld |-> $past(rd_req))
    else $error("stray read answer");
  AST_ZERO: assert property (hit && io.wr && io.wdata == 8'h00 && !running |=> !running)
    else $error("zero code started timer");
  AST_PULSE: assert property ($rose(cpu_rst) |-> s_pulse ##1 !cpu_rst)
    else $error("reset pulse length");
  AST_EXPIRE: assert property (s_last ##1 !running |-> (irq_mode ? irq : cpu_rst))
    else $error("expiry without action");
  AST_EARLY: assert property (running && remain > 6'h01 && !req |=> running)
    else $error("early expiry");
  AST_STEP: assert property (running && !req |=> remain == $past(remain) || remain == $past(remain) - 6'h01)
    else $error("count step");
  AST_MODE: assert property (!(cpu_rst && irq_mode) && !(irq && !irq_mode))
    else $error("wrong expiry kind");
  AST_IRQCLR: assert property (irq && (load || rd_req) |=> !irq)
    else $error("interrupt not cleared");
endmodule
bind iwd_top iwd_monitor i_iwd_monitor (.clk_sys, .rstn, .io, .irq_mode, .rdata_vld,
  .cpu_rst, .irq, .running, .remain);

// >>> testbench/iwd_host.sv
/* Host processor model making single byte port accesses.
   Assumes callers run in the clk_sys domain. */
module iwd_host (
  input  wire logic        clk_sys, // Clock.
  output iwd_pkg::iwd_io_s io       // Port access.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial io = '0;
  // One-cycle strobe; released address and data are inverted and strobes cleared so stale values never look valid.
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    #1;
    io.addr = a;
    io.wdata = d;
    io.wr = w;
    io.rd = !w;
    @(posedge clk_sys);
    #1;
    io.addr = ~io.addr;
    io.wdata = ~io.wdata;
    io.wr = 1'b0;
    io.rd = 1'b0;
  endtask
endmodule

// >>> testbench/testbench.sv
/* Self-checking watchdog bench with a ten-cycle second.
   Assumes the host model drives the port. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 10;
  localparam logic [15:0] PA = iwd_pkg::IWD_PORT_ADDR;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] pon_sel = 2'h1;
  logic irq_mode = 1'b0;
  iwd_pkg::iwd_io_s io;
  logic [7:0] rdata;
  logic rdata_vld, cpu_rst, irq, running;
  logic [5:0] remain;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  iwd_host i_iwd_host (.clk_sys, .io);
  iwd_top #(.TICK_CYC(TC)) i_iwd_top (.clk_sys, .rstn, .io, .pon_sel, .irq_mode, .rdata,
    .rdata_vld, .cpu_rst, .irq, .running, .remain);
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    for (int s = 0; s < 4; s++) begin
      rstn = 1'b0;
      pon_sel = 2'(s);
      wait_cyc(12);
      rstn = 1'b1;
      wait_cyc(2);
      check("pon_run", running, 8'(s != 1));
      check("pon_ivl", remain, (s == 0) ? 8'h3F : (s == 2) ? 8'h1F : (s == 3) ? 8'h0F : 8'h00);
    end
    $display("test power-on done");
    i_iwd_host.acc(PA, 8'h00, 1'b0);
    check("rd_run", running, 8'h00);
    check("rd_vld", rdata_vld, 8'h01);
    check("rd_data", rdata, iwd_pkg::IWD_READ_DATA);
    i_iwd_host.acc(16'h0442, 8'h05, 1'b1);
    check("bad_addr", running, 8'h00);
    i_iwd_host.acc(PA, 8'h00, 1'b1);
    check("zero", running, 8'h00);
    i_iwd_host.acc(PA, 8'h40, 1'b1);
    check("over", running, 8'h00);
    wait_cyc(4 * TC);
    check("idle_rst", cpu_rst, 8'h00);
    $display("test disarm done");
    i_iwd_host.acc(PA, 8'h02, 1'b1);
    check("ld_ivl", remain, 8'h02);
    wait_cyc(TC + 1);
    check("tick", remain, 8'h01);
    wait_cyc(TC - 2);
    check("not_early", running, 8'h01);
    wait_cyc(2);
    check("fire", cpu_rst, 8'h01);
    wait_cyc(16);
    check("pulse_end", cpu_rst, 8'h00);
    i_iwd_host.acc(PA, 8'h01, 1'b1);
    wait_cyc(TC - 3);
    i_iwd_host.acc(PA, 8'h01, 1'b1);
    wait_cyc(TC - 3);
    check("refresh", running, 8'h01);
    check("no_fire", cpu_rst, 8'h00);
    $display("test reset mode done");
    irq_mode = 1'b1;
    i_iwd_host.acc(PA, 8'h3F, 1'b1);
    check("max_ivl", remain, 8'h3F);
    i_iwd_host.acc(PA, 8'h01, 1'b1);
    wait_cyc(TC + 2);
    check("irq", irq, 8'h01);
    check("irq_norst", cpu_rst, 8'h00);
    i_iwd_host.acc(PA, 8'h00, 1'b0);
    check("irq_clr", irq, 8'h00);
    $display("test irq mode done");
    summarize();
  end
endmodule
